/* design/ebce_core.v */
// Purpose: 8-bit core that executes one instruction at a time from program memory
// Assumes: program memory and data ram answer combinationally in the same cycle
// Notes: one instruction cycle per clk_sys edge; halts while the run bit is clear
// How it works
// - add/subtract with carry update accumulator, carry, half carry; carry is inverted borrow
// - mask test ands accumulator with immediate, skips on zero; 2 bytes 2 cycles
// - equal, unequal, greater, memory-versus-immediate tests skip next when false
// - pointer nibble test runs next only when low B nibble differs
// - count down decrements F0-FF register, skips on zero; 1 byte 3 cycles
// - bit set and clear force one selected memory bit, others kept
// - bit test runs next only when the selected bit is one
// - pending clear drops software interrupt pending flag in 1 byte 1 cycle
// - pointer loads, exchanges, stores in their step forms use pointer then step it by one
// - bcd fix corrects accumulator from carry and half carry of prior add/sub
// - rotate left through carry, half carry takes old bit 0
// - rotate right through carry as a 9-bit ring
// - push writes then decrements; pop increments then reads; 1 byte 3 cycles
// - program counter is 15 bits: 7 upper and 8 lower
// - long jump loads 15 bits in 3/4; near jump loads low 12 in 2/3
// - relative jump adds -31..+32 in 1/3; displacement one not encodable
// - calls push low then high byte, lower stack by two; 3/5 and 2/5
// - boot call pushes, loads low byte, clears high, enters boot space
// - returns raise stack by two, reload counter in 5; skip and irq variants
// - trap pushes return address, lowers stack by two, jumps to 0FF in 1/7
// - vector dispatch loads counter from two adjacent program bytes in 1/5
// - table fetch and table jump read {high,accumulator} in 3 cycles
// - skipped instruction takes one cycle per byte; alu forms 1/1, 2/2, 3/4
// - near jump and page call keep the top three counter bits
// - a skipped instruction changes no register and no memory
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`include "ebce_defs.vh"

module ebce_core (
  input wire clk_sys, // 40 MHz clock
  input wire rstn, // async reset, active low
  input wire [3:0] avs_address, // register byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall request
  output reg [14:0] pm_addr, // program memory address
  input wire [7:0] pm_rdata, // program memory byte
  output reg [7:0] dm_addr, // data ram address
  input wire [7:0] dm_rdata, // data ram byte
  output reg [7:0] dm_wdata, // data ram write byte
  output reg dm_we, // data ram write enable
  input wire [14:0] vec_addr, // vector table address from irq logic
  output wire global_irq_enable, // interrupt enable flag
  output wire swi_pending, // software interrupt pending
  output wire boot_space // executing from boot space
);

  reg [14:0] pc_r;
  reg [7:0] acc_r, b_r, x_r, sp_r, op0_r, b1_r, b2_r, tmp_r;
  reg c_r, hc_r, sub_r, skip_r, gie_r, pend_r, boot_r, run_r, ack_r;
  reg [2:0] cyc_r;

  // byte count and cycle count of an opcode
  function [4:0] shape;
    input [7:0] op;
    begin
      casez (op)
        8'h00: shape = {2'd1, 3'd7};
        8'hE0: shape = {2'd1, 3'd1}; // no-op filler, single cycle like any no-operation
        8'b000?????, 8'b111?????: shape = {2'd1, 3'd3};
        8'h2?: shape = {2'd2, 3'd3};
        8'h3?, 8'h61: shape = {2'd2, 3'd5};
        8'h60, 8'h9?: shape = {2'd2, 3'd2};
        8'h67, 8'h8C, 8'hA4, 8'hA5, 8'hB2, 8'hB3: shape = {2'd1, 3'd3};
        8'hB8, 8'hBA, 8'hBB, 8'hBE, 8'hC?: shape = {2'd1, 3'd3};
        8'h8D, 8'h8E, 8'h8F, 8'hB4: shape = {2'd1, 3'd5};
        8'hA2, 8'hA3, 8'hAA, 8'hAB: shape = {2'd1, 3'd2};
        8'hA9: shape = {2'd3, 3'd3};
        8'hAC, 8'hBD: shape = {2'd3, 3'd4};
        8'hAD: shape = {2'd3, 3'd5};
        default: shape = {2'd1, 3'd1};
      endcase
      if (op == 8'h9C || op == 8'h9D)
        shape = {2'd2, 3'd3};
    end
  endfunction

  wire [7:0] op0 = (cyc_r == 3'h0) ? pm_rdata : op0_r;
  wire [7:0] b1 = (cyc_r == 3'h1) ? pm_rdata : b1_r;
  wire [7:0] b2 = (cyc_r == 3'h2) ? pm_rdata : b2_r;
  wire [4:0] shp = shape(op0);
  wire [1:0] nb = shp[4:3];
  wire [2:0] ncyc = skip_r ? {1'b0, nb} : shp[2:0];
  wire last = (cyc_r == ncyc - 3'h1);
  wire prev = (cyc_r == ncyc - 3'h2);
  wire [14:0] pc_seq = pc_r + {13'h0000, nb};
  wire is_call = (op0 == `EBCE_OP_TRAP) || (op0[7:4] == 4'h3) ||
                 (op0 == `EBCE_OP_BOOTCALL) || (op0 == `EBCE_OP_LCALL);
  wire is_ret = (op0 == `EBCE_OP_BACK) || (op0 == `EBCE_OP_BACKSKIP) ||
                (op0 == `EBCE_OP_IRQBACK);

  // the direct form carries its memory operation in the third byte
  wire direct = (op0 == `EBCE_OP_DIRECT);
  wire [7:0] aop = direct ? b2 : op0;
  wire [7:0] ea = direct ? b1 : b_r;
  wire [7:0] mval = (op0[7:4] == 4'h9) ? b1 : dm_rdata;

  wire [8:0] adc_s = {1'b0, acc_r} + {1'b0, mval} + {8'h00, c_r};
  wire [4:0] adc_h = {1'b0, acc_r[3:0]} + {1'b0, mval[3:0]} + {4'h0, c_r};
  wire [8:0] sbc_s = {1'b0, acc_r} + {1'b0, ~mval} + {8'h00, c_r};
  wire [4:0] sbc_h = {1'b0, acc_r[3:0]} + {1'b0, ~mval[3:0]} + {4'h0, c_r};
  wire dec_lo = sub_r ? ~hc_r : (hc_r | (acc_r[3:0] > 4'h9));
  wire dec_hi = sub_r ? ~c_r : (c_r | (acc_r > 8'h99));
  wire [7:0] adj = (dec_hi ? 8'h60 : 8'h00) | (dec_lo ? 8'h06 : 8'h00);
  wire [7:0] bcd_v = sub_r ? acc_r - adj : acc_r + adj;
  wire [7:0] bitmask = 8'h01 << aop[2:0];

  // register bus: one wait cycle, then the answer
  wire req = avs_read | avs_write;
  wire ctl_wr = avs_write & ack_r & (avs_address == `EBCE_OFS_CTRL);
  assign avs_waitrequest = req & ~ack_r;
  assign global_irq_enable = gie_r;
  assign swi_pending = pend_r;
  assign boot_space = boot_r;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      run_r <= `EBCE_RUN_RST;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (ctl_wr)
        run_r <= avs_writedata[`EBCE_CTRL_RUN];
      if (req & ~ack_r) begin
        case (avs_address)
          `EBCE_OFS_CTRL: avs_readdata <= {29'h0, boot_r, gie_r, run_r};
          `EBCE_OFS_STAT: avs_readdata <= {11'h0, boot_r, pend_r, gie_r, hc_r, c_r, skip_r, pc_r};
          `EBCE_OFS_DATA: avs_readdata <= {sp_r, x_r, b_r, acc_r};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // memory addressing per cycle
  always @* begin
    pm_addr = pc_r + {12'h000, cyc_r};
    dm_addr = b_r;
    dm_we = 1'b0;
    dm_wdata = acc_r;
    if (run_r && !skip_r) begin
      if (op0 == `EBCE_OP_TFETCH || op0 == `EBCE_OP_TJUMP) begin
        if (last)
          pm_addr = {pc_r[14:8], acc_r};
      end else if (op0 == `EBCE_OP_VECTOR) begin
        if (cyc_r == 3'h3)
          pm_addr = vec_addr;
        else if (last)
          pm_addr = vec_addr + 15'h0001;
      end
      if (is_call) begin
        dm_addr = prev ? sp_r : sp_r - 8'h01;
        dm_wdata = prev ? pc_seq[7:0] : {1'b0, pc_seq[14:8]};
        dm_we = prev | last;
      end else if (is_ret) begin
        dm_addr = last ? sp_r + 8'h01 : sp_r + 8'h02;
      end else begin
        casez (aop)
          8'b0110_1???, 8'b0111_1???: begin
            dm_addr = ea;
            dm_wdata = aop[4] ? (dm_rdata | bitmask) : (dm_rdata & ~bitmask);
            dm_we = last;
          end
          8'h67: begin
            dm_addr = sp_r;
            dm_we = last;
          end
          8'h8C: dm_addr = sp_r + 8'h01;
          8'h9A, 8'h9B, 8'h9E: begin
            dm_wdata = b1;
            dm_we = last;
          end
          8'h9C, 8'h9D, 8'hA9: begin
            dm_addr = b1;
            dm_we = last & (aop == `EBCE_OP_XAMD);
          end
          8'hA2, 8'hA3, 8'hA6: dm_we = last;
          8'hB2, 8'hB3, 8'hB8: begin
            dm_addr = x_r;
            dm_we = last;
          end
          8'hBA, 8'hBB, 8'hBE: dm_addr = x_r;
          8'hC?: begin
            dm_addr = {4'hF, aop[3:0]};
            dm_wdata = dm_rdata - 8'h01;
            dm_we = last;
          end
          default: dm_addr = ea;
        endcase
      end
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_r <= `EBCE_PC_RST;
      sp_r <= `EBCE_SP_RST;
      acc_r <= 8'h00;
      b_r <= 8'h00;
      x_r <= 8'h00;
      op0_r <= 8'h00;
      b1_r <= 8'h00;
      b2_r <= 8'h00;
      tmp_r <= 8'h00;
      cyc_r <= 3'h0;
      {c_r, hc_r, sub_r, skip_r, gie_r, pend_r, boot_r} <= 7'h00;
    end else begin
      if (ctl_wr) begin
        gie_r <= avs_writedata[`EBCE_CTRL_GIE];
        if (avs_writedata[`EBCE_CTRL_BOOT])
          boot_r <= 1'b0;
      end
      if (run_r) begin
        if (cyc_r == 3'h0)
          op0_r <= pm_rdata;
        if (cyc_r == 3'h1)
          b1_r <= pm_rdata;
        if (cyc_r == 3'h2)
          b2_r <= pm_rdata;
        if (cyc_r == 3'h3)
          tmp_r <= (op0_r == `EBCE_OP_VECTOR) ? pm_rdata : dm_rdata;
        if (!last)
          cyc_r <= cyc_r + 3'h1;
        else begin
          cyc_r <= 3'h0;
          pc_r <= pc_seq;
          if (skip_r)
            skip_r <= 1'b0;
          else begin
            casez (aop)
              8'h00: begin
                pc_r <= `EBCE_TRAP_PC;
                sp_r <= sp_r - 8'h02;
                pend_r <= 1'b1;
              end
              8'hE0: ;
              8'b000?????: pc_r <= pc_r + {10'h000, aop[4:0]} + 15'h0001;
              8'b111?????: pc_r <= pc_r + {{7{aop[7]}}, aop};
              8'h2?: pc_r <= {pc_r[14:12], aop[3:0], b1};
              8'h3?: begin
                pc_r <= {pc_r[14:12], aop[3:0], b1};
                sp_r <= sp_r - 8'h02;
              end
              8'h4?: if (b_r[3:0] == aop[3:0]) skip_r <= 1'b1;
              8'h5?: b_r <= {4'h0, ~aop[3:0]};
              8'h60: if ((acc_r & b1) == 8'h00) skip_r <= 1'b1;
              8'h61: begin
                pc_r <= {7'h00, b1};
                sp_r <= sp_r - 8'h02;
                boot_r <= 1'b1;
              end
              8'h64: acc_r <= 8'h00;
              8'h65: acc_r <= {acc_r[3:0], acc_r[7:4]};
              8'h66: begin
                acc_r <= bcd_v;
                c_r <= sub_r ? c_r : (c_r | dec_hi);
              end
              8'h67: sp_r <= sp_r - 8'h01;
              8'b0111_0???: if (!dm_rdata[aop[2:0]]) skip_r <= 1'b1;
              8'h80, 8'h90: begin
                {c_r, acc_r} <= adc_s;
                hc_r <= adc_h[4];
                sub_r <= 1'b0;
              end
              8'h81, 8'h91: begin
                {c_r, acc_r} <= sbc_s;
                hc_r <= sbc_h[4];
                sub_r <= 1'b1;
              end
              8'h82, 8'h92: if (acc_r != mval) skip_r <= 1'b1;
              8'h83, 8'h93: if (!(acc_r > mval)) skip_r <= 1'b1;
              8'h84, 8'h94: acc_r <= acc_r + mval;
              8'h85, 8'h95: acc_r <= acc_r & mval;
              8'h86, 8'h96: acc_r <= acc_r ^ mval;
              8'h87, 8'h97: acc_r <= acc_r | mval;
              8'h88: if (!c_r) skip_r <= 1'b1;
              8'h89: if (c_r) skip_r <= 1'b1;
              8'h8A: acc_r <= acc_r + 8'h01;
              8'h8B: acc_r <= acc_r - 8'h01;
              8'h8C: begin
                sp_r <= sp_r + 8'h01;
                acc_r <= dm_rdata;
              end
              8'h8D, 8'h8E, 8'h8F: begin
                sp_r <= sp_r + 8'h02;
                pc_r <= {dm_rdata[6:0], tmp_r};
                if (aop == `EBCE_OP_BACKSKIP)
                  skip_r <= 1'b1;
                if (aop == `EBCE_OP_IRQBACK)
                  gie_r <= 1'b1;
              end
              8'h98, 8'h9F: if (aop[0]) b_r <= b1; else acc_r <= b1;
              8'h99: if (acc_r == b1) skip_r <= 1'b1;
              8'h9A, 8'h9B: b_r <= aop[0] ? b_r - 8'h01 : b_r + 8'h01;
              8'h9C, 8'h9D, 8'hA6, 8'hAE, 8'hB8, 8'hBE: acc_r <= dm_rdata;
              8'hA0, 8'hA1: {c_r, hc_r} <= {2{aop[0]}};
              8'hA2, 8'hA3, 8'hAA, 8'hAB: begin
                acc_r <= dm_rdata;
                b_r <= aop[0] ? b_r - 8'h01 : b_r + 8'h01;
              end
              8'hA4: acc_r <= pm_rdata;
              8'hA5: pc_r <= {pc_r[14:8], pm_rdata};
              8'hA8: begin
                {c_r, acc_r} <= {acc_r, c_r};
                hc_r <= acc_r[0];
              end
              8'hA9: if (dm_rdata != b2) skip_r <= 1'b1;
              8'hAC, 8'hAD: begin
                pc_r <= {b1[6:0], b2};
                if (aop[0])
                  sp_r <= sp_r - 8'h02;
              end
              8'hB0: {acc_r, c_r} <= {c_r, acc_r};
              8'hB2, 8'hB3, 8'hBA, 8'hBB: begin
                acc_r <= dm_rdata;
                x_r <= aop[0] ? x_r - 8'h01 : x_r + 8'h01;
              end
              8'hB4: pc_r <= {tmp_r[6:0], pm_rdata};
              8'hB5: pend_r <= 1'b0;
              8'hC?: if (dm_rdata == 8'h01) skip_r <= 1'b1;
              default: ;
            endcase
          end
        end
      end
    end
  end

endmodule // ebce_core

/* design/ebce_defs.vh */
// Purpose: constants shared by the instruction execution core
// Assumes: included by its bare name
// Notes: opcodes are the core's byte encodings
`ifndef EBCE_DEFS_VH
`define EBCE_DEFS_VH

// register bus byte offsets
`define EBCE_OFS_CTRL 4'h0
`define EBCE_OFS_STAT 4'h4
`define EBCE_OFS_DATA 4'h8

// control register fields
`define EBCE_CTRL_RUN 0
`define EBCE_CTRL_GIE 1
`define EBCE_CTRL_BOOT 2

// reset values and the trap target
`define EBCE_RUN_RST 1'b1
`define EBCE_SP_RST 8'h6F
`define EBCE_PC_RST 15'h0000
`define EBCE_TRAP_PC 15'h00FF

// single opcodes
`define EBCE_OP_TRAP 8'h00
`define EBCE_OP_JPZ 8'hE0
`define EBCE_OP_MASKSKIP 8'h60
`define EBCE_OP_BOOTCALL 8'h61
`define EBCE_OP_CLRA 8'h64
`define EBCE_OP_SWAPA 8'h65
`define EBCE_OP_BCDFIX 8'h66
`define EBCE_OP_PUSHA 8'h67
`define EBCE_OP_IFC 8'h88
`define EBCE_OP_IFNC 8'h89
`define EBCE_OP_INCA 8'h8A
`define EBCE_OP_DECA 8'h8B
`define EBCE_OP_POPA 8'h8C
`define EBCE_OP_BACKSKIP 8'h8D
`define EBCE_OP_BACK 8'h8E
`define EBCE_OP_IRQBACK 8'h8F
`define EBCE_OP_LDAI 8'h98
`define EBCE_OP_IFNEI 8'h99
`define EBCE_OP_LDBPI 8'h9A
`define EBCE_OP_LDBMI 8'h9B
`define EBCE_OP_XAMD 8'h9C
`define EBCE_OP_LDAMD 8'h9D
`define EBCE_OP_LDBI 8'h9E
`define EBCE_OP_LDB8 8'h9F
`define EBCE_OP_RC 8'hA0
`define EBCE_OP_SC 8'hA1
`define EBCE_OP_XBP 8'hA2
`define EBCE_OP_XBM 8'hA3
`define EBCE_OP_TFETCH 8'hA4
`define EBCE_OP_TJUMP 8'hA5
`define EBCE_OP_XB 8'hA6
`define EBCE_OP_ROTL 8'hA8
`define EBCE_OP_IFEQMD 8'hA9
`define EBCE_OP_LDBP 8'hAA
`define EBCE_OP_LDBM 8'hAB
`define EBCE_OP_LJUMP 8'hAC
`define EBCE_OP_LCALL 8'hAD
`define EBCE_OP_LDB 8'hAE
`define EBCE_OP_ROTR 8'hB0
`define EBCE_OP_XXP 8'hB2
`define EBCE_OP_XXM 8'hB3
`define EBCE_OP_VECTOR 8'hB4
`define EBCE_OP_PENDCLR 8'hB5
`define EBCE_OP_XX 8'hB8
`define EBCE_OP_LDXP 8'hBA
`define EBCE_OP_LDXM 8'hBB
`define EBCE_OP_DIRECT 8'hBD
`define EBCE_OP_LDX 8'hBE

`endif

/* dv/ebce_core_sva.sv */
// Purpose: port-level checks for the instruction execution core
// Assumes: bound to ebce_core, one clock domain
// Notes: the halted state is tracked from accepted control writes
module ebce_core_sva (
  input wire clk_sys, // clock
  input wire rstn, // async reset, active low
  input wire [3:0] avs_address, // register address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // stall
  input wire [14:0] pm_addr, // program address
  input wire [7:0] dm_addr, // ram address
  input wire [7:0] dm_wdata, // ram write data
  input wire dm_we, // ram write enable
  input wire boot_space, // boot space flag
  input wire swi_pending // software pending flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic halted_r;
  wire req = avs_read | avs_write;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // run bit takes effect from the cycle after the accepting edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) halted_r <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0) halted_r <= !avs_writedata[0];
  end
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request taken without a wait cycle");
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && !(avs_address inside {4'h0, 4'h4, 4'h8}) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_read_stands: assert property (!req |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  chk_halt_nowrite: assert property (halted_r |-> !dm_we)
    else $error("ram written while halted");
  chk_halt_frozen: assert property (halted_r && $past(halted_r) |-> $stable(pm_addr))
    else $error("fetch moved while halted");
  chk_trap_entry: assert property (
    $rose(swi_pending) |-> pm_addr == 15'h00FF && $past(dm_we) && $past(dm_we, 2)
      && $past(dm_addr, 2) - 8'h01 == $past(dm_addr) && $past(dm_wdata) < 8'h80)
    else $error("trap entry wrong");
  chk_boot_entry: assert property (
    $rose(boot_space) |-> pm_addr[14:8] == 7'h00 && $past(dm_we) && $past(dm_we, 2))
    else $error("boot call entry wrong");
endmodule // ebce_core_sva

bind ebce_core ebce_core_sva ebce_core_sva_i (.clk_sys(clk_sys), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .dm_addr(dm_addr),
  .dm_wdata(dm_wdata), .dm_we(dm_we), .boot_space(boot_space), .swi_pending(swi_pending));

/* dv/ebce_mem_model.sv */
// Purpose: program memory and data ram seen by the core
// Assumes: both answer combinationally, ram writes at the rising edge
// Notes: contents are loaded by the bench between runs
module ebce_mem_model (
  input wire clk_sys, // clock
  input wire [14:0] pm_addr, // program address
  output wire [7:0] pm_rdata, // program byte
  input wire [7:0] dm_addr, // ram address
  output wire [7:0] dm_rdata, // ram byte
  input wire [7:0] dm_wdata, // ram write byte
  input wire dm_we // ram write enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pm [0:32767];
  logic [7:0] dm [0:255];
  assign pm_rdata = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];
  always @(posedge clk_sys) begin
    if (dm_we) dm[dm_addr] <= dm_wdata;
  end
endmodule // ebce_mem_model

/* dv/test_eight_bit_core_instruction_exec.sv */
// Purpose: self-checking bench for the instruction execution core
// Assumes: every program ends by falling or jumping into a loop at 0x040
// Notes: cycles are counted from reset release until the loop is first fetched
module test_eight_bit_core_instruction_exec;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [63:0] p; logic [31:0] d; logic [4:0] fv; logic [4:0] fm;
    logic [15:0] m; int c;} ebce_row_t;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [14:0] vec_addr = 15'h0120;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, dm_we, global_irq_enable, swi_pending, boot_space;
  wire [14:0] pm_addr;
  wire [7:0] pm_rdata, dm_addr, dm_rdata, dm_wdata;
  int err_total = 0;
  int check_count = 0;
  int cyc_n = 0;
  logic [31:0] rd;
  // program bytes, {sp,x,b,a}, flags {boot,pend,gie,hc,c} and mask, ram {addr,byte}, cycles
  ebce_row_t rows [28] = '{
    '{64'h983CA19049E0E0E0, 32'h6F000086, 5'h02, 5'h03, 16'h005A, 64},
    '{64'h9825A19137E0E0E0, 32'h6F0000EE, 5'h00, 5'h03, 16'h005A, 64},
    '{64'h9815A0902766E0E0, 32'h6F000042, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h98F0600F64E0E0E0, 32'h6F0000F0, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h98F0601064E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h980792078AE0E0E0, 32'h6F000008, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h980799078AE0E0E0, 32'h6F000007, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h980793088AE0E0E0, 32'h6F000007, 5'h00, 5'h00, 16'h005A, 64},
    '{64'hA9005A8AE0E0E0E0, 32'h6F000001, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h5A458AE0E0E0E0E0, 32'h6F000500, 5'h00, 5'h00, 16'h005A, 64},
    '{64'hC08AE0E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'hF000, 66},
    '{64'h708AE0E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h718AE0E0E0E0E0E0, 32'h6F000001, 5'h00, 5'h00, 16'h005A, 64},
    '{64'h786EE0E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h001B, 64},
    '{64'hAAAAE0E0E0E0E0E0, 32'h6F0002C3, 5'h00, 5'h00, 16'h005A, 66},
    '{64'h9A77E0E0E0E0E0E0, 32'h6F000100, 5'h00, 5'h00, 16'h0077, 64},
    '{64'h9881A0A8E0E0E0E0, 32'h6F000002, 5'h03, 5'h03, 16'h005A, 64},
    '{64'h9881A1B0E0E0E0E0, 32'h6F0000C0, 5'h01, 5'h01, 16'h005A, 64},
    '{64'h983C67648CE0E0E0, 32'h6F00003C, 5'h00, 5'h00, 16'h6F3C, 68},
    '{64'hAC0040E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h005A, 4},
    '{64'h1FE0E0E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h005A, 35},
    '{64'h3050E0E0E0E0E0E0, 32'h6F000001, 5'h00, 5'h00, 16'h6F02, 73},
    '{64'h00E0E0E0E0E0E0E0, 32'h6D000000, 5'h00, 5'h08, 16'h6F01, 12},
    '{64'hB4E0E0E0E0E0E0E0, 32'h6F000000, 5'h00, 5'h00, 16'h005A, 5},
    '{64'h9880A4E0E0E0E0E0, 32'h6F000040, 5'h00, 5'h00, 16'h005A, 66},
    '{64'h9880A5E0E0E0E0E0, 32'h6F000080, 5'h00, 5'h00, 16'h005A, 5},
    '{64'h8FE0E0E0E0E0E0E0, 32'h71000000, 5'h04, 5'h04, 16'h005A, 5},
    '{64'h6140E0E0E0E0E0E0, 32'h6D000000, 5'h10, 5'h10, 16'h6F02, 5}};

  always #12.5 clk_sys = ~clk_sys;

  ebce_core ebce_core_i (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .vec_addr(vec_addr), .global_irq_enable(global_irq_enable),
    .swi_pending(swi_pending), .boot_space(boot_space));
  ebce_mem_model ebce_mem_model_i (.clk_sys(clk_sys), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));

  task results;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hung run still ends through the closing report
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 10000) begin
      err_total++;
      results();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request is held until the edge that sees waitrequest low; read data is taken at that edge
  // a hang here is ended by the cycle ceiling, not by a local count
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task load(input logic [63:0] p);
    for (int i = 0; i < 8; i++) ebce_mem_model_i.pm[i] = p[63-8*i -: 8];
    ebce_mem_model_i.dm[8'h00] = 8'h5A;
    ebce_mem_model_i.dm[8'h01] = 8'hC3;
    ebce_mem_model_i.dm[8'hF0] = 8'h01;
    ebce_mem_model_i.dm[8'h6F] = 8'h00;
    ebce_mem_model_i.dm[8'h70] = 8'h00;
    ebce_mem_model_i.dm[8'h71] = 8'h40;
  endtask

  initial begin
    int n;
    for (int i = 0; i < 32768; i++) ebce_mem_model_i.pm[i] = 8'hE0;
    // loop at 0x040, subroutine at 0x050, table byte, trap and vector targets
    {ebce_mem_model_i.pm[15'h40], ebce_mem_model_i.pm[15'h41]} = 16'h2040;
    {ebce_mem_model_i.pm[15'h50], ebce_mem_model_i.pm[15'h51]} = 16'h8A8E;
    ebce_mem_model_i.pm[15'h80] = 8'h40;
    ebce_mem_model_i.pm[15'hFF] = 8'hB5;
    {ebce_mem_model_i.pm[15'h100], ebce_mem_model_i.pm[15'h101]} = 16'hAC00;
    ebce_mem_model_i.pm[15'h102] = 8'h40;
    {ebce_mem_model_i.pm[15'h120], ebce_mem_model_i.pm[15'h121]} = 16'h0040;
    load(64'hE0E0E0E0E0E0E0E0);
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(4'h0, 32'h00000001);
    rdchk(4'h8, 32'h6F000000);
    rdchk(4'hC, 32'h00000000);
    for (int i = 0; i < 28; i++) begin
      @(posedge clk_sys);
      rstn <= 1'b0;
      load(rows[i].p);
      // two edges in reset so the reset drop of read data is never seen as a change
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      n = 0;
      #1;
      while (pm_addr !== 15'h0040 && n < 300) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      check(32'(n), 32'(rows[i].c));
      bus(1'b0, 4'h8, 32'h0);
      check(rd, rows[i].d);
      bus(1'b0, 4'h4, 32'h0);
      check({27'h0, rd[20:16] & rows[i].fm}, {27'h0, rows[i].fv});
      check({27'h0, {boot_space, swi_pending, global_irq_enable, 2'b00} & rows[i].fm},
        {27'h0, rows[i].fv & 5'h1C});
      check({17'h0, rd[14:0]}, 32'h00000040);
      check({24'h0, ebce_mem_model_i.dm[rows[i].m[15:8]]}, {24'h0, rows[i].m[7:0]});
    end
    // halt, set the enable and leave boot space in one control write
    bus(1'b1, 4'h0, 32'h00000006);
    rdchk(4'h0, 32'h00000002);
    rdchk(4'h4, 32'h00040040);
    bus(1'b1, 4'h4, 32'hFFFFFFFF);
    rdchk(4'h8, 32'h6D000000);
    bus(1'b1, 4'h0, 32'h00000001);
    rdchk(4'h0, 32'h00000001);
    results();
  end
endmodule // test_eight_bit_core_instruction_exec
